// file: hw/dtc_regs.svh
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_ADDR_CONTROL  8'h88
`define DTC_ADDR_MODE     8'h89
`define DTC_ADDR_LOW_ZERO 8'h8a
`define DTC_ADDR_LOW_ONE  8'h8b
`define DTC_ADDR_HIGH_ZERO 8'h8c
`define DTC_ADDR_HIGH_ONE  8'h8d

`define DTC_CON_OVF_ONE   7
`define DTC_CON_RUN_ONE   6
`define DTC_CON_OVF_ZERO  5
`define DTC_CON_RUN_ZERO  4
`define DTC_CON_EXT_ONE   3
`define DTC_CON_TYPE_ONE  2
`define DTC_CON_EXT_ZERO  1
`define DTC_CON_TYPE_ZERO 0

`define DTC_MOD_GATE_ONE  7
`define DTC_MOD_CT_ONE    6
`define DTC_MOD_MODE_ONE_HI 5
`define DTC_MOD_MODE_ONE_LO 4
`define DTC_MOD_GATE_ZERO 3
`define DTC_MOD_CT_ZERO   2
`define DTC_MOD_MODE_ZERO_HI 1
`define DTC_MOD_MODE_ZERO_LO 0

`define DTC_RESET_BYTE    8'h00
`define DTC_PRESCALE      4'hc

`endif

// file: hw/dtc_pkg.sv
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_MODE_13     = 2'b00,
		DTC_MODE_16     = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT  = 2'b11
	} dtc_mode_t;
endpackage : dtc_pkg

// file: hw/dtc_chan_if.sv
`timescale 1ns/100ps
interface dtc_chan_if;
	import dtc_pkg::*;
	dtc_mode_t   mode;
	logic        inc_lo;
	logic        inc_hi;
	logic        wr_lo;
	logic        wr_hi;
	logic [7:0]  wdata;
	logic [7:0]  lo;
	logic [7:0]  hi;
	logic        ovf_lo;
	logic        ovf_hi;
	modport ctl  (output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
		input lo, hi, ovf_lo, ovf_hi);
	modport chan (input mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
		output lo, hi, ovf_lo, ovf_hi);
endinterface : dtc_chan_if

// file: hw/dtc_edge_sync.sv
`timescale 1ns/100ps
module dtc_edge_sync (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level,
	output logic      fall
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// meta_r feeds only sync_r
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign fall  = prev_r & ~sync_r;
endmodule : dtc_edge_sync

// file: hw/dtc_channel.sv
`timescale 1ns/100ps
module dtc_channel
	import dtc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	dtc_chan_if.chan ch
);
	`include "dtc_regs.svh"

	logic [7:0] lo_r;
	logic [7:0] lo_nxt;
	logic [7:0] hi_r;
	logic [7:0] hi_nxt;
	logic       ovf_lo_nxt;
	logic       ovf_hi_nxt;

	function automatic logic [8:0] dtc_inc8(input logic [7:0] v);
		return {1'b0, v} + 9'h001;
	endfunction : dtc_inc8

	always_comb begin
		logic [8:0] s;
		s = 9'h000;
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		ovf_lo_nxt = 1'b0;
		ovf_hi_nxt = 1'b0;
		case (ch.mode)
			DTC_MODE_13: begin
				if (ch.inc_lo) begin // see R7
					lo_nxt = {3'b000, lo_r[4:0] + 5'h01};
					if (&lo_r[4:0]) begin
						{ovf_lo_nxt, hi_nxt} = dtc_inc8(hi_r); // see R18
					end
				end
			end
			DTC_MODE_16: begin
				if (ch.inc_lo) begin
					s = dtc_inc8(lo_r);
					lo_nxt = s[7:0];
					if (s[8]) begin
						{ovf_lo_nxt, hi_nxt} = dtc_inc8(hi_r); // see R18
					end
				end
			end
			DTC_MODE_RELOAD: begin
				if (ch.inc_lo) begin
					s = dtc_inc8(lo_r);
					lo_nxt = s[8] ? hi_r : s[7:0]; // see R8
					ovf_lo_nxt = s[8]; // see R18
				end
			end
			DTC_MODE_SPLIT: begin
				if (ch.inc_lo) begin
					{ovf_lo_nxt, lo_nxt} = dtc_inc8(lo_r); // see R10
				end
				if (ch.inc_hi) begin
					{ovf_hi_nxt, hi_nxt} = dtc_inc8(hi_r); // see R10
				end
			end
			default: begin
				lo_nxt = lo_r;
			end
		endcase
		// a software write wins over a count in the same cycle
		if (ch.wr_lo) begin
			lo_nxt = ch.wdata;
		end
		if (ch.wr_hi) begin
			hi_nxt = ch.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lo_r <= `DTC_RESET_BYTE;
			hi_r <= `DTC_RESET_BYTE;
		end else begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end

	// top bits read as zero in 13-bit mode even if written
	assign ch.lo     = (ch.mode == DTC_MODE_13) ?
		{3'b000, lo_r[4:0]} : lo_r; // see R7
	assign ch.hi     = hi_r;
	assign ch.ovf_lo = ovf_lo_nxt;
	assign ch.ovf_hi = ovf_hi_nxt;
endmodule : dtc_channel

// file: hw/dtc_unit.sv
`timescale 1ns/100ps
// Function
// R1 - timer operation counts once every twelve clocks while running
// R2 - counter operation advances on each falling edge of the count input
// R3 - edge seen over two samples; inputs countable up to half clock
// R4 - sources hold each level at least one machine cycle
// R5 - run bits 6 and 4 of control enable channel one and zero
// R6 - two-bit mode field picks 13-bit, 16-bit, reload or split
// R7 - 13-bit mode uses five low bits, top three held zero
// R8 - reload mode reloads low byte from high byte on wrap
// R9 - channel one in mode three stops counting
// R10 - channel zero mode three splits into two 8-bit counters
// R11 - software avoids channel zero reload with channel one 13/16-bit
// R12 - count-source bit one means counter, zero means timer
// R13 - gate set counts falling edges of gate signal when running
// R14 - overflow sets flag; software or service clears it
// R15 - falling edge on interrupt pin sets edge flag; service clears
// R16 - type bit selects edge or level request per interrupt pin
// R17 - type zero means low level, type one means falling edge
// R18 - overflow is wrap of active width, flagged same cycle
module dtc_unit
	import dtc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	input  wire logic       count_input_zero,
	input  wire logic       count_input_one,
	input  wire logic       gate_input_zero,
	input  wire logic       gate_input_one,
	input  wire logic       ext_irq_pin_zero,
	input  wire logic       ext_irq_pin_one,
	input  wire logic       irq_ack_ovf_zero,
	input  wire logic       irq_ack_ovf_one,
	input  wire logic       irq_ack_ext_zero,
	input  wire logic       irq_ack_ext_one,
	output logic            overflow_flag_zero,
	output logic            overflow_flag_one,
	output logic            ext_irq_zero_flag,
	output logic            ext_irq_one_flag,
	output logic            ext_irq_req_zero,
	output logic            ext_irq_req_one
);
	`include "dtc_regs.svh"

	logic [7:0] mode_r;
	logic       run_zero_r;
	logic       run_one_r;
	logic       type_zero_r;
	logic       type_one_r;
	logic       ovf_zero_r;
	logic       ovf_one_r;
	logic       ext_zero_r;
	logic       ext_one_r;
	logic       req_zero_r;
	logic       req_one_r;
	logic [7:0] rdata_r;
	logic [3:0] presc_r;
	logic       tick;

	logic       cnt0_fall;
	logic       cnt1_fall;
	logic       gate0_fall;
	logic       gate1_fall;
	logic       irq0_lvl;
	logic       irq0_fall;
	logic       irq1_lvl;
	logic       irq1_fall;

	logic       wr_con;
	logic       wr_mod;
	logic       ev_zero;
	logic       ev_one;
	logic       set_ovf_zero;
	logic       set_ovf_one;
	dtc_mode_t  mode_zero;
	dtc_mode_t  mode_one;
	logic       gate_zero;
	logic       gate_one;
	logic       ct_zero;
	logic       ct_one;

	dtc_chan_if ch0 ();
	dtc_chan_if ch1 ();

	// every pin passes two flops before the edge detector looks at it
	dtc_edge_sync u_sync_cnt0 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pin   (count_input_zero),
		.level (),
		.fall  (cnt0_fall)
	);
	dtc_edge_sync u_sync_cnt1 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pin   (count_input_one),
		.level (),
		.fall  (cnt1_fall)
	);
	dtc_edge_sync u_sync_gate0 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pin   (gate_input_zero),
		.level (),
		.fall  (gate0_fall)
	);
	dtc_edge_sync u_sync_gate1 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pin   (gate_input_one),
		.level (),
		.fall  (gate1_fall)
	);
	dtc_edge_sync u_sync_irq0 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pin   (ext_irq_pin_zero),
		.level (irq0_lvl),
		.fall  (irq0_fall)
	);
	dtc_edge_sync u_sync_irq1 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pin   (ext_irq_pin_one),
		.level (irq1_lvl),
		.fall  (irq1_fall)
	);

	dtc_channel u_chan_zero (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ch    (ch0.chan)
	);
	dtc_channel u_chan_one (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ch    (ch1.chan)
	);

	// one write decode shared by every writable register
	function automatic logic dtc_wr_hit(
		input logic       wr,
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return wr & (addr == target);
	endfunction : dtc_wr_hit

	assign wr_con = dtc_wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_CONTROL);
	assign wr_mod = dtc_wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_MODE);

	// mode field decode
	assign mode_zero = dtc_mode_t'(mode_r[`DTC_MOD_MODE_ZERO_HI:
		`DTC_MOD_MODE_ZERO_LO]); // see R6
	assign mode_one  = dtc_mode_t'(mode_r[`DTC_MOD_MODE_ONE_HI:
		`DTC_MOD_MODE_ONE_LO]); // see R6
	assign gate_zero = mode_r[`DTC_MOD_GATE_ZERO];
	assign gate_one  = mode_r[`DTC_MOD_GATE_ONE];
	assign ct_zero   = mode_r[`DTC_MOD_CT_ZERO];
	assign ct_one    = mode_r[`DTC_MOD_CT_ONE];

	// free-running prescaler; phase is not reset by a run bit
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			presc_r <= 4'h0;
		end else if (presc_r == `DTC_PRESCALE - 4'h1) begin
			presc_r <= 4'h0; // see R1
		end else begin
			presc_r <= presc_r + 4'h1;
		end
	end
	assign tick = (presc_r == `DTC_PRESCALE - 4'h1);

	// count events; gate mode counts gate falling edges
	assign ev_zero = run_zero_r & (gate_zero ? gate0_fall : // see R13
		(ct_zero ? cnt0_fall : tick)); // see R2 see R3 see R12 see R5
	assign ev_one  = run_one_r & (gate_one ? gate1_fall : // see R13
		(ct_one ? cnt1_fall : tick)); // see R2 see R12 see R5

	assign ch0.mode   = mode_zero;
	assign ch0.inc_lo = ev_zero;
	// split high byte counts clock ticks under channel one's run bit
	assign ch0.inc_hi = (mode_zero == DTC_MODE_SPLIT) &
		run_one_r & tick; // see R10
	assign ch0.wr_lo  = dtc_wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_LOW_ZERO);
	assign ch0.wr_hi  = dtc_wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_HIGH_ZERO);
	assign ch0.wdata  = sfr_wdata;

	assign ch1.mode   = mode_one;
	assign ch1.inc_lo = ev_one & (mode_one != DTC_MODE_SPLIT); // see R9
	assign ch1.inc_hi = 1'b0;
	assign ch1.wr_lo  = dtc_wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_LOW_ONE);
	assign ch1.wr_hi  = dtc_wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_HIGH_ONE);
	assign ch1.wdata  = sfr_wdata;

	assign set_ovf_zero = ch0.ovf_lo; // see R18
	assign set_ovf_one  = ch1.ovf_lo | ch0.ovf_hi; // see R10

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode_r <= `DTC_RESET_BYTE;
		end else if (wr_mod) begin
			mode_r <= sfr_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_zero_r  <= 1'b0;
			run_one_r   <= 1'b0;
			type_zero_r <= 1'b0;
			type_one_r  <= 1'b0;
		end else if (wr_con) begin
			run_zero_r  <= sfr_wdata[`DTC_CON_RUN_ZERO]; // see R5
			run_one_r   <= sfr_wdata[`DTC_CON_RUN_ONE]; // see R5
			type_zero_r <= sfr_wdata[`DTC_CON_TYPE_ZERO];
			type_one_r  <= sfr_wdata[`DTC_CON_TYPE_ONE];
		end
	end

	// flags: a hardware set beats a write or a service clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ovf_zero_r <= 1'b0;
			ovf_one_r  <= 1'b0;
		end else begin
			ovf_zero_r <= set_ovf_zero | (wr_con ?
				sfr_wdata[`DTC_CON_OVF_ZERO] :
				(ovf_zero_r & ~irq_ack_ovf_zero)); // see R14
			ovf_one_r  <= set_ovf_one | (wr_con ?
				sfr_wdata[`DTC_CON_OVF_ONE] :
				(ovf_one_r & ~irq_ack_ovf_one)); // see R14
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ext_zero_r <= 1'b0;
			ext_one_r  <= 1'b0;
		end else begin
			ext_zero_r <= irq0_fall | (wr_con ?
				sfr_wdata[`DTC_CON_EXT_ZERO] :
				(ext_zero_r & ~irq_ack_ext_zero)); // see R15
			ext_one_r  <= irq1_fall | (wr_con ?
				sfr_wdata[`DTC_CON_EXT_ONE] :
				(ext_one_r & ~irq_ack_ext_one)); // see R15
		end
	end

	// level requests follow the pin, so they cannot be cleared by service
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			req_zero_r <= 1'b0;
			req_one_r  <= 1'b0;
		end else begin
			req_zero_r <= type_zero_r ? ext_zero_r :
				~irq0_lvl; // see R16 see R17
			req_one_r  <= type_one_r ? ext_one_r :
				~irq1_lvl; // see R16 see R17
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_r <= `DTC_RESET_BYTE;
		end else if (sfr_rd) begin
			case (sfr_addr)
				`DTC_ADDR_CONTROL: begin
					rdata_r <= {ovf_one_r, run_one_r, ovf_zero_r,
						run_zero_r, ext_one_r, type_one_r,
						ext_zero_r, type_zero_r};
				end
				`DTC_ADDR_MODE: begin
					rdata_r <= mode_r;
				end
				`DTC_ADDR_LOW_ZERO: begin
					rdata_r <= ch0.lo;
				end
				`DTC_ADDR_LOW_ONE: begin
					rdata_r <= ch1.lo;
				end
				`DTC_ADDR_HIGH_ZERO: begin
					rdata_r <= ch0.hi;
				end
				`DTC_ADDR_HIGH_ONE: begin
					rdata_r <= ch1.hi;
				end
				default: begin
					rdata_r <= 8'h00;
				end
			endcase
		end
	end

	assign sfr_rdata          = rdata_r;
	assign overflow_flag_zero = ovf_zero_r;
	assign overflow_flag_one  = ovf_one_r;
	assign ext_irq_zero_flag  = ext_zero_r;
	assign ext_irq_one_flag   = ext_one_r;
	assign ext_irq_req_zero   = req_zero_r;
	assign ext_irq_req_one    = req_one_r;
endmodule : dtc_unit

// file: testbench/dtc_unit_props.sv
`timescale 1ns/100ps
module dtc_unit_props (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       ext_irq_pin_zero,
	input wire logic       ext_irq_pin_one,
	input wire logic       irq_ack_ovf_zero,
	input wire logic       irq_ack_ovf_one,
	input wire logic       irq_ack_ext_one,
	input wire logic       overflow_flag_zero,
	input wire logic       overflow_flag_one,
	input wire logic       ext_irq_one_flag,
	input wire logic       ext_irq_zero_flag,
	input wire logic       ext_irq_req_zero
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic ctl_wr;
	assign ctl_wr = sfr_wr && sfr_addr == 8'h88;
	ovf_zero_clear_a: assert property ($fell(overflow_flag_zero)
		|-> $past(irq_ack_ovf_zero) || $past(ctl_wr))
		else $error("flag zero dropped without cause");
	ovf_one_clear_a: assert property ($fell(overflow_flag_one)
		|-> $past(irq_ack_ovf_one) || $past(ctl_wr))
		else $error("flag one dropped without cause");
	ext_rise_a: assert property ($rose(ext_irq_one_flag) |->
		$past(ctl_wr) || !$past(ext_irq_pin_one, 2) ||
		!$past(ext_irq_pin_one, 3) || !$past(ext_irq_pin_one, 4))
		else $error("edge flag set without a falling edge");
	ext_ack_a: assert property (ext_irq_pin_one[*6] ##0
		(irq_ack_ext_one && !ctl_wr) |=> !ext_irq_one_flag)
		else $error("edge flag survived service");
	req_idle_a: assert property (
		(ext_irq_pin_zero && !ext_irq_zero_flag)[*6] |-> !ext_irq_req_zero)
		else $error("request without pin or flag");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	unmapped_rd_a: assert property (sfr_rd &&
		(sfr_addr < 8'h88 || sfr_addr > 8'h8d) |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	mode_back_a: assert property (sfr_wr && sfr_addr == 8'h89 ##1
		!sfr_wr ##1 sfr_rd && !sfr_wr && sfr_addr == 8'h89
		|=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("mode register read back wrong");
endmodule : dtc_unit_props

bind dtc_unit dtc_unit_props i_props (
	.mclk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
	.ext_irq_pin_zero, .ext_irq_pin_one, .irq_ack_ovf_zero,
	.irq_ack_ovf_one, .irq_ack_ext_one, .overflow_flag_zero,
	.overflow_flag_one, .ext_irq_one_flag, .ext_irq_zero_flag,
	.ext_irq_req_zero
);

// file: testbench/dtc_far_model.sv
`timescale 1ns/100ps
module dtc_far_model (
	input  wire logic mclk,
	output logic      count_input_zero,
	output logic      count_input_one,
	output logic      gate_input_zero,
	output logic      gate_input_one,
	output logic      ext_irq_pin_zero,
	output logic      ext_irq_pin_one
);
	logic [5:0] pins_r = 6'h3f;
	assign {ext_irq_pin_one, ext_irq_pin_zero, gate_input_one,
		gate_input_zero, count_input_one, count_input_zero} = pins_r;
	task automatic hold(input logic [5:0] v);
		@(negedge mclk);
		pins_r = v;
	endtask : hold
	// w of 2 leaves margin for the input synchroniser
	task automatic pulse(input logic [5:0] sel, input int n, input int w);
		repeat (n) begin
			hold(pins_r & ~sel);
			repeat (w - 1) @(negedge mclk);
			hold(pins_r | sel);
			repeat (w - 1) @(negedge mclk);
		end
	endtask : pulse
endmodule : dtc_far_model

// file: testbench/dtc_unit_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module dtc_unit_tb;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic       sfr_wr = 1'b0;
	logic       sfr_rd = 1'b0;
	logic [7:0] sfr_rdata;
	logic [3:0] ack = 4'h0;
	wire  [5:0] pin;
	wire  [5:0] st;
	logic       f0;
	int         errors = 0;
	int         checked = 0;
	int         cyc = 0;
	always #5 mclk = ~mclk;
	dtc_far_model i_far (.mclk, .count_input_zero(pin[0]),
		.count_input_one(pin[1]), .gate_input_zero(pin[2]),
		.gate_input_one(pin[3]), .ext_irq_pin_zero(pin[4]),
		.ext_irq_pin_one(pin[5]));
	dtc_unit i_dut (.mclk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
		.sfr_rd, .sfr_rdata, .count_input_zero(pin[0]),
		.count_input_one(pin[1]), .gate_input_zero(pin[2]),
		.gate_input_one(pin[3]), .ext_irq_pin_zero(pin[4]),
		.ext_irq_pin_one(pin[5]), .irq_ack_ovf_zero(ack[0]),
		.irq_ack_ovf_one(ack[1]), .irq_ack_ext_zero(ack[2]),
		.irq_ack_ext_one(ack[3]), .overflow_flag_zero(st[0]),
		.overflow_flag_one(st[1]), .ext_irq_zero_flag(st[2]),
		.ext_irq_one_flag(st[3]), .ext_irq_req_zero(st[4]),
		.ext_irq_req_one(st[5]));
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask : idle
	// two-cycle accesses so a strobe is never dropped and raised together
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		idle(1);
		sfr_wr = 1'b0;
		idle(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_rd = 1'b1;
		sfr_addr = a;
		idle(1);
		sfr_rd = 1'b0;
		`CHK("rdata", e, sfr_rdata)
		idle(1);
	endtask : rd
	task automatic ackp(input logic [3:0] m);
		ack = m;
		idle(1);
		ack = 4'h0;
	endtask : ackp
	task automatic waitf(input int b);
		repeat (20) if (st[b] !== 1'b1) idle(1);
	endtask : waitf
	// one prescaler tick lands inside the twelve running cycles
	task automatic tick1(input logic [7:0] c);
		wr(8'h88, c);
		idle(10);
		f0 = st[0];
		wr(8'h88, 8'h00);
		f0 = f0 | st[0];
	endtask : tick1
	task automatic clr_counts();
		for (int a = 8'h8a; a < 8'h8e; a++) wr(a[7:0], 8'h00);
	endtask : clr_counts
	task automatic conclude();
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		idle(4);
		rst_n = 1'b1;
		rd(8'h88, 8'h00);
		rd(8'h90, 8'h00);
		wr(8'h89, 8'h00);
		rd(8'h89, 8'h00);
		wr(8'h8a, 8'hff);
		rd(8'h8a, 8'h1f);
		wr(8'h8c, 8'h05);
		tick1(8'h10);
		`CHK("ovf0", 1'b0, f0)
		idle(12);
		rd(8'h8a, 8'h00);
		rd(8'h8c, 8'h06);
		wr(8'h89, 8'h01);
		rd(8'h89, 8'h01);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'hff);
		wr(8'h88, 8'h10);
		waitf(0);
		`CHK("ovf0", 1'b1, st[0])
		ackp(4'h1);
		`CHK("ovf0", 1'b0, st[0])
		idle(47);
		rd(8'h8a, 8'h04);
		rd(8'h8c, 8'h00);
		wr(8'h89, 8'h22);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'ha5);
		wr(8'h88, 8'h10);
		waitf(0);
		`CHK("ovf0", 1'b1, st[0])
		wr(8'h88, 8'h00);
		rd(8'h8a, 8'ha5);
		wr(8'h89, 8'h33);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'hff);
		wr(8'h8b, 8'h77);
		wr(8'h88, 8'h50);
		waitf(0);
		`CHK("ovf1", 1'b1, st[1])
		wr(8'h88, 8'h00);
		`CHK("ovf1", 1'b0, st[1])
		rd(8'h8c, 8'h00);
		rd(8'h8b, 8'h77);
		wr(8'h89, 8'h20);
		wr(8'h8b, 8'hff);
		wr(8'h8d, 8'h3c);
		wr(8'h88, 8'h40);
		waitf(1);
		`CHK("ovf1", 1'b1, st[1])
		ackp(4'h2);
		`CHK("ovf1", 1'b0, st[1])
		wr(8'h88, 8'h00);
		rd(8'h8b, 8'h3c);
		wr(8'h89, 8'h55);
		clr_counts();
		wr(8'h88, 8'h50);
		i_far.pulse(6'h03, 3, 2);
		idle(3);
		wr(8'h88, 8'h00);
		rd(8'h8a, 8'h03);
		rd(8'h8b, 8'h03);
		wr(8'h89, 8'h99);
		clr_counts();
		wr(8'h88, 8'h50);
		i_far.pulse(6'h0c, 2, 2);
		idle(3);
		wr(8'h88, 8'h00);
		rd(8'h8a, 8'h02);
		rd(8'h8b, 8'h02);
		i_far.pulse(6'h0c, 1, 2);
		idle(3);
		rd(8'h8a, 8'h02);
		wr(8'h88, 8'h05);
		i_far.pulse(6'h30, 1, 2);
		idle(6);
		`CHK("irq", 4'hf, st[5:2])
		ackp(4'hc);
		idle(2);
		`CHK("irq", 4'h0, st[5:2])
		wr(8'h88, 8'h00);
		i_far.hold(6'h2f);
		idle(5);
		`CHK("req0", 1'b1, st[4])
		i_far.hold(6'h3f);
		idle(5);
		`CHK("req0", 1'b0, st[4])
		conclude();
	end
endmodule : dtc_unit_tb
